// file: mzbi_bus_interface_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "mzbi_regs.svh"
// Overview of operation
// - Flat 16 MB byte space, 24-bit address decoded into zones.
// - 000000h-03FFFFh is program flash, static zone 0.
// - 0D0000h-0D1FFFh is data flash, static zone 0.
// - 400000h-7FFFFFh goes external using zone 1 timing.
// - 800000h-FEFFFFh goes external using zone 2 timing.
// - Operating mode latched at reset from boot pins and blank flags.
// - Pins 111 give internal code mode, or IN_SYSTEM_PROGRAM_MODE if flash blank.
// - Pins 011 give external code mode, or IN_SYSTEM_PROGRAM_MODE if flash blank.
// - Pins 110 give IN_SYSTEM_PROGRAM_MODE mode always.
// - Off-chip mode disables flash, zone 0 goes external.
// - Off-chip internal-zone0 mode keeps zone 0 on chip.
// - Normal read is two clocks, fast read one clock.
// - Reads are normal after reset.
// - Late write two clocks, early write three clocks.
// - Wait clocks follow the address phase.
// - Hold clocks end the cycle with write data held.
// - Write timing bit 0 selects early write; byte register resets 07h.
// - Five config registers at FFF900h..FFF908h, even addresses.
// - Three-bit wait field adds 0..7 wait clocks per access, none on fast reads.
// - Two-bit hold field adds 0..3 hold clocks per access, none on fast reads.
// - Post-idle bit adds one idle clock before a different zone.
module mzbi_bus_interface_unit (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave from the core
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [23:0] wb_adr_i,
  input  wire logic [1:0]  wb_sel_i,
  input  wire logic [15:0] wb_dat_i,
  output logic      [15:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Boot straps
  input  wire logic [2:0]  boot_config_pins_i,
  input  wire logic        flash_blank_i,
  // Target memory side
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic             mem_onchip_o,
  output logic [2:0]       mem_zone_o,
  output logic [23:0]      mem_adr_o,
  output logic [15:0]      mem_wdat_o,
  output logic             mem_wdat_oe_o,
  input  wire logic [15:0] mem_rdat_i,
  output logic [2:0]       op_mode_o
);

  logic [2:0]  pins_s1_r;
  logic [2:0]  pins_s2_r;
  logic        blank_s1_r;
  logic        blank_s2_r;
  logic        boot_done_r;
  mzbi_pkg::mzbi_mode_e  mode_r;
  logic [7:0]  wtc_r;
  logic [15:0] ioz_r;
  logic [15:0] sz0_r;
  logic [15:0] sz1_r;
  logic [15:0] sz2_r;
  mzbi_pkg::mzbi_state_e st_r;
  mzbi_pkg::mzbi_zone_e  zone_r;
  mzbi_pkg::mzbi_zone_e  last_zone_r;
  logic        last_post_idle_select_r;
  logic [3:0]  cnt_r;
  logic [1:0]  hold_r;
  logic [15:0] cfg_sel;
  mzbi_pkg::mzbi_zone_e  zone_dec;
  logic        req;
  logic        reg_hit;
  logic [15:0] reg_rd;

  // Address to zone decode
  function automatic mzbi_pkg::mzbi_zone_e dec_zone(input logic [23:0] a);
    if (a <= `MZBI_PFL_HI) begin
      dec_zone = mzbi_pkg::MZBI_ZN_Z0;
    end else if (a >= `MZBI_DFL_LO && a <= `MZBI_DFL_HI) begin
      dec_zone = mzbi_pkg::MZBI_ZN_Z0;
    end else if (a >= `MZBI_Z1_LO && a <= `MZBI_Z1_HI) begin
      dec_zone = mzbi_pkg::MZBI_ZN_Z1;
    end else if (a >= `MZBI_Z2_LO && a <= `MZBI_Z2_HI) begin
      dec_zone = mzbi_pkg::MZBI_ZN_Z2;
    end else if (a >= `MZBI_IO_LO && a <= `MZBI_IO_HI) begin
      dec_zone = mzbi_pkg::MZBI_ZN_IO;
    end else if (a >= `MZBI_ADR_WTC && a <= `MZBI_ADR_STAT) begin
      dec_zone = mzbi_pkg::MZBI_ZN_REG;
    end else begin
      dec_zone = mzbi_pkg::MZBI_ZN_NONE; // Reserved space answers with err
    end
  endfunction : dec_zone

  assign req      = wb_cyc_i & wb_stb_i;
  assign zone_dec = dec_zone(wb_adr_i);
  assign reg_hit  = zone_dec == mzbi_pkg::MZBI_ZN_REG;

  // Two-stage synchroniser on straps
  always_ff @(posedge clk_i) begin
    pins_s1_r  <= boot_config_pins_i;
    pins_s2_r  <= pins_s1_r;
    blank_s1_r <= flash_blank_i;
    blank_s2_r <= blank_s1_r;
  end

  // Mode captured once after reset release, straps settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_done_r <= 1'b0;
      mode_r      <= mzbi_pkg::MZBI_MD_ISP;
    end else if (!boot_done_r) begin
      boot_done_r <= 1'b1;
      unique case (pins_s2_r)
        `MZBI_ENV_IRE: mode_r <= blank_s2_r ? mzbi_pkg::MZBI_MD_ISP
                                            : mzbi_pkg::MZBI_MD_INTERNAL;
        `MZBI_ENV_ERE: mode_r <= blank_s2_r ? mzbi_pkg::MZBI_MD_ISP
                                            : mzbi_pkg::MZBI_MD_EXTERNAL;
        `MZBI_ENV_ISP: mode_r <= mzbi_pkg::MZBI_MD_ISP;
        `MZBI_ENV_DEV: mode_r <= mzbi_pkg::MZBI_MD_OFFCHIP;
        `MZBI_ENV_OFFCHIP_CODE_INTERNAL_ZONE0_MODE: mode_r <= mzbi_pkg::MZBI_MD_OFFCHIP_Z0I;
        default: mode_r <= mzbi_pkg::MZBI_MD_ISP;
      endcase
    end
  end

  assign op_mode_o = mode_r;

  // Timing configuration of the decoded zone
  always_comb begin
    unique case (zone_dec)
      mzbi_pkg::MZBI_ZN_Z0: cfg_sel = sz0_r;
      mzbi_pkg::MZBI_ZN_Z1: cfg_sel = sz1_r;
      mzbi_pkg::MZBI_ZN_Z2: cfg_sel = sz2_r;
      mzbi_pkg::MZBI_ZN_IO: cfg_sel = {4'h0, 1'b0, ioz_r[10:0]}; // No fast read here
      default:              cfg_sel = 16'h0000;
    endcase
  end

  // Register writes, taken on the acking edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wtc_r <= `MZBI_WTC_RST;
      ioz_r <= `MZBI_ZONE_RST;
      sz0_r <= `MZBI_ZONE_RST; // Fast read bit clear after reset
      sz1_r <= `MZBI_ZONE_RST;
      sz2_r <= `MZBI_ZONE_RST;
    end else if (req && wb_we_i && reg_hit && !wb_ack_o) begin
      unique case (wb_adr_i)
        `MZBI_ADR_WTC: if (wb_sel_i[0]) wtc_r <= wb_dat_i[7:0];
        `MZBI_ADR_IOZ: begin
          if (wb_sel_i[0]) ioz_r[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) ioz_r[15:8] <= wb_dat_i[15:8];
        end
        `MZBI_ADR_SZ0: begin
          if (wb_sel_i[0]) sz0_r[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) sz0_r[15:8] <= wb_dat_i[15:8];
        end
        `MZBI_ADR_SZ1: begin
          if (wb_sel_i[0]) sz1_r[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) sz1_r[15:8] <= wb_dat_i[15:8];
        end
        `MZBI_ADR_SZ2: begin
          if (wb_sel_i[0]) sz2_r[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) sz2_r[15:8] <= wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
  end

  // Register read mux
  always_comb begin
    unique case (wb_adr_i)
      `MZBI_ADR_WTC:  reg_rd = {8'h00, wtc_r};
      `MZBI_ADR_IOZ:  reg_rd = ioz_r;
      `MZBI_ADR_SZ0:  reg_rd = sz0_r;
      `MZBI_ADR_SZ1:  reg_rd = sz1_r;
      `MZBI_ADR_SZ2:  reg_rd = sz2_r;
      `MZBI_ADR_STAT: reg_rd = {13'h0000, mode_r};
      default:        reg_rd = 16'h0000;
    endcase
  end

  // Memory cycle sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r        <= mzbi_pkg::MZBI_ST_IDLE;
      zone_r      <= mzbi_pkg::MZBI_ZN_NONE;
      last_zone_r <= mzbi_pkg::MZBI_ZN_NONE;
      last_post_idle_select_r <= 1'b0;
      cnt_r       <= 4'h0;
      hold_r      <= 2'h0;
    end else begin
      unique case (st_r)
        mzbi_pkg::MZBI_ST_IDLE: begin
          if (req && !wb_ack_o && !reg_hit && zone_dec != mzbi_pkg::MZBI_ZN_NONE) begin
            zone_r <= zone_dec;
            hold_r <= cfg_sel[`MZBI_F_HOLD_LO +: 2];
            if (last_post_idle_select_r && last_zone_r != zone_dec) begin
              st_r <= mzbi_pkg::MZBI_ST_POST; // One idle clock first
            end else begin
              st_r <= mzbi_pkg::MZBI_ST_BASE;
            end
            // Basic length minus the first clock
            if (wb_we_i) begin
              cnt_r <= {1'b0, (wtc_r[`MZBI_F_EWR] ? (`MZBI_WR_EARLY - 3'h1)
                                                 : (`MZBI_WR_LATE - 3'h1))};
            end else begin
              cnt_r <= {1'b0, (cfg_sel[`MZBI_F_FRE] ? (`MZBI_RD_FAST - 3'h1)
                                                   : (`MZBI_RD_NORM - 3'h1))};
            end
          end
        end
        mzbi_pkg::MZBI_ST_POST: st_r <= mzbi_pkg::MZBI_ST_BASE;
        mzbi_pkg::MZBI_ST_BASE: begin
          // Wait clocks come right after the address phase
          if (!cfg_sel[`MZBI_F_FRE] || wb_we_i) begin
            if (cfg_sel[`MZBI_F_WAIT_LO +: 3] != 3'h0) begin
              st_r  <= mzbi_pkg::MZBI_ST_WAIT;
              // Four bits: early write plus seven waits reaches eight
              cnt_r <= cnt_r + {1'b0, cfg_sel[`MZBI_F_WAIT_LO +: 3]} - 4'h1;
            end else if (cnt_r != 4'h0) begin
              st_r  <= mzbi_pkg::MZBI_ST_WAIT;
              cnt_r <= cnt_r - 4'h1;
            end else begin
              st_r <= (hold_r != 2'h0) ? mzbi_pkg::MZBI_ST_HOLD : mzbi_pkg::MZBI_ST_DONE;
            end
          end else begin
            st_r <= mzbi_pkg::MZBI_ST_DONE; // Fast read ignores wait and hold
          end
        end
        mzbi_pkg::MZBI_ST_WAIT: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            st_r <= (hold_r != 2'h0) ? mzbi_pkg::MZBI_ST_HOLD : mzbi_pkg::MZBI_ST_DONE;
          end
        end
        mzbi_pkg::MZBI_ST_HOLD: begin
          hold_r <= hold_r - 2'h1;
          if (hold_r == 2'h1) st_r <= mzbi_pkg::MZBI_ST_DONE;
        end
        mzbi_pkg::MZBI_ST_DONE: begin
          st_r        <= mzbi_pkg::MZBI_ST_IDLE;
          last_zone_r <= zone_r;
          last_post_idle_select_r <= cfg_sel[`MZBI_F_POST_IDLE_SELECT];
        end
        default: st_r <= mzbi_pkg::MZBI_ST_IDLE;
      endcase
    end
  end

  // Wishbone answer, one cycle pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 16'h0000;
    end else begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      if (req && !wb_ack_o && !wb_err_o) begin
        if (reg_hit) begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= reg_rd;
        end else if (zone_dec == mzbi_pkg::MZBI_ZN_NONE) begin
          wb_err_o <= 1'b1;
        end else if (st_r == mzbi_pkg::MZBI_ST_DONE) begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= mem_rdat_i;
        end
      end
    end
  end

  // Target strobes; zone 0 off chip in plain off-chip mode
  always_comb begin
    mem_req_o     = st_r != mzbi_pkg::MZBI_ST_IDLE && st_r != mzbi_pkg::MZBI_ST_POST;
    mem_we_o      = mem_req_o & wb_we_i;
    mem_zone_o    = zone_r;
    mem_adr_o     = wb_adr_i;
    mem_wdat_o    = wb_dat_i;
    mem_wdat_oe_o = mem_we_o; // Held through hold clocks
    mem_onchip_o  = (zone_r == mzbi_pkg::MZBI_ZN_Z0 && mode_r != mzbi_pkg::MZBI_MD_OFFCHIP)
                    || zone_r == mzbi_pkg::MZBI_ZN_IO;
  end

endmodule : mzbi_bus_interface_unit
`default_nettype wire

// file: mzbi_regs.svh
`ifndef MZBI_REGS_SVH
`define MZBI_REGS_SVH
// Register word offsets (byte address = offset, all even)
`define MZBI_ADR_WTC      24'hfff900
`define MZBI_ADR_IOZ      24'hfff902
`define MZBI_ADR_SZ0      24'hfff904
`define MZBI_ADR_SZ1      24'hfff906
`define MZBI_ADR_SZ2      24'hfff908
`define MZBI_ADR_STAT     24'hfff90a
// Reset values
`define MZBI_WTC_RST      8'h07
`define MZBI_ZONE_RST     16'h069f
// Zone and write timing field positions
`define MZBI_F_WAIT_LO    0
`define MZBI_F_HOLD_LO    3
`define MZBI_F_POST_IDLE_SELECT       9
`define MZBI_F_FRE        11
`define MZBI_F_EWR        0
// Decode ranges
`define MZBI_PFL_LO       24'h000000
`define MZBI_PFL_HI       24'h03ffff
`define MZBI_DFL_LO       24'h0d0000
`define MZBI_DFL_HI       24'h0d1fff
`define MZBI_Z1_LO        24'h400000
`define MZBI_Z1_HI        24'h7fffff
`define MZBI_Z2_LO        24'h800000
`define MZBI_Z2_HI        24'hfeffff
`define MZBI_IO_LO        24'hfffb00
`define MZBI_IO_HI        24'hfffbff
// Basic cycle lengths in clocks
`define MZBI_RD_NORM      3'h2
`define MZBI_RD_FAST      3'h1
`define MZBI_WR_LATE      3'h2
`define MZBI_WR_EARLY     3'h3
// Boot pin codes
`define MZBI_ENV_IRE      3'h7
`define MZBI_ENV_ERE      3'h3
`define MZBI_ENV_ISP      3'h6
`define MZBI_ENV_DEV      3'h0
`define MZBI_ENV_OFFCHIP_CODE_INTERNAL_ZONE0_MODE   3'h1
`endif

// file: mzbi_pkg.sv
package mzbi_pkg;
  typedef enum logic [2:0] {
    MZBI_ZN_NONE = 3'h0,
    MZBI_ZN_Z0   = 3'h1,
    MZBI_ZN_Z1   = 3'h2,
    MZBI_ZN_Z2   = 3'h3,
    MZBI_ZN_IO   = 3'h4,
    MZBI_ZN_REG  = 3'h5
  } mzbi_zone_e;
  typedef enum logic [2:0] {
    MZBI_MD_INTERNAL    = 3'h0,
    MZBI_MD_EXTERNAL    = 3'h1,
    MZBI_MD_OFFCHIP     = 3'h2,
    MZBI_MD_OFFCHIP_Z0I = 3'h3,
    MZBI_MD_ISP         = 3'h4
  } mzbi_mode_e;
  typedef enum logic [2:0] {
    MZBI_ST_IDLE = 3'h0,
    MZBI_ST_BASE = 3'h1,
    MZBI_ST_WAIT = 3'h3,
    MZBI_ST_HOLD = 3'h2,
    MZBI_ST_DONE = 3'h6,
    MZBI_ST_POST = 3'h7
  } mzbi_state_e;
endpackage : mzbi_pkg

// file: mzbi_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Port checks of the bus interface unit
module mzbi_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [23:0] wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        mem_req_o,
  input wire logic        mem_onchip_o,
  input wire logic [2:0]  mem_zone_o,
  input wire logic [23:0] mem_adr_o,
  input wire logic [2:0]  op_mode_o
);
  logic take;
  logic mq;
  logic rst_d_r = 1'b0;
  // Reset seen at the previous edge, low before the first edge
  always_ff @(posedge clk_i) begin
    rst_d_r <= rst_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // New request and live memory cycle
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mq   = mem_req_o && wb_cyc_i;
  AST_REG_ACK: assert property (
    take && wb_adr_i inside {[24'hfff900:24'hfff90a]} |=> wb_ack_o)
    else $error("register access not answered next cycle");
  AST_RSV_ERR: assert property (
    take && wb_adr_i inside {[24'h040000:24'h0cffff]} |=> wb_err_o && !wb_ack_o)
    else $error("reserved access not refused");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_PF_ZONE: assert property (mq && mem_adr_o <= 24'h03ffff |-> mem_zone_o == 3'h1)
    else $error("program flash not zone 0");
  AST_DF_ZONE: assert property (
    mq && mem_adr_o inside {[24'h0d0000:24'h0d1fff]} |-> mem_zone_o == 3'h1)
    else $error("data flash not zone 0");
  AST_Z1_ZONE: assert property (
    mq && mem_adr_o inside {[24'h400000:24'h7fffff]} |-> mem_zone_o == 3'h2)
    else $error("zone 1 range misrouted");
  AST_Z2_ZONE: assert property (
    mq && mem_adr_o inside {[24'h800000:24'hfeffff]} |-> mem_zone_o == 3'h3)
    else $error("zone 2 range misrouted");
  AST_DEV_EXT: assert property (
    mq && mem_zone_o == 3'h1 && op_mode_o == 3'h2 |-> !mem_onchip_o)
    else $error("zone 0 kept on chip in off-chip mode");
  AST_Z0_INT: assert property (
    mq && mem_zone_o == 3'h1 && op_mode_o inside {3'h0, 3'h1, 3'h3} |-> mem_onchip_o)
    else $error("zone 0 sent off chip");
  AST_RST_MODE: assert property (
    disable iff (1'b0) rst_i && rst_d_r |-> op_mode_o == 3'h4)
    else $error("mode not forced during reset");
endmodule : mzbi_monitor
bind mzbi_bus_interface_unit mzbi_monitor i_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .mem_req_o(mem_req_o),
  .mem_onchip_o(mem_onchip_o), .mem_zone_o(mem_zone_o), .mem_adr_o(mem_adr_o),
  .op_mode_o(op_mode_o));
`default_nettype wire

// file: mzbi_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mzbi_mem_model (
  input  wire logic        clk_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [23:0] mem_adr_i,
  input  wire logic [15:0] mem_wdat_i,
  input  wire logic        mem_wdat_oe_i,
  output logic      [15:0] mem_rdat_o
);
  logic [15:0] mem_r [16];
  logic [15:0] junk_r = 16'h1234;
  // Store driven write data, scramble the idle bus
  always_ff @(posedge clk_i) begin
    junk_r <= ~junk_r ^ 16'h5a5a;
    if (mem_req_i && mem_we_i && mem_wdat_oe_i)
      mem_r[mem_adr_i[4:1]] <= mem_wdat_i;
  end
  // Drive data only in a read cycle
  assign mem_rdat_o = (mem_req_i && !mem_we_i) ? mem_r[mem_adr_i[4:1]] : junk_r;
endmodule : mzbi_mem_model
`default_nettype wire

// file: mzbi_bus_interface_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module mzbi_bus_interface_unit_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [23:0] wb_adr_i = 24'h0;
  logic [15:0] wb_dat_i = 16'h0, wb_dat_o, mem_wdat_o, mem_rdat_i, rd;
  logic        wb_ack_o, wb_err_o, mem_req_o, mem_we_o, mem_onchip_o, mem_wdat_oe_o, er;
  logic [2:0]  boot_config_pins_i = 3'h7, mem_zone_o, op_mode_o;
  logic        flash_blank_i = 1'b0;
  logic [23:0] mem_adr_o;
  int          err_count = 0, check_count = 0, lat;
  // Straps, blank flag, expected mode
  logic [6:0]  boot_tab [8] = '{7'h70, 7'h7c, 7'h31, 7'h3c, 7'h64, 7'h0a, 7'h1b, 7'h70};

  always #50 clk_i = ~clk_i;

  mzbi_bus_interface_unit i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(2'h3), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .boot_config_pins_i(boot_config_pins_i), .flash_blank_i(flash_blank_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_onchip_o(mem_onchip_o),
    .mem_zone_o(mem_zone_o), .mem_adr_o(mem_adr_o), .mem_wdat_o(mem_wdat_o),
    .mem_wdat_oe_o(mem_wdat_oe_o), .mem_rdat_i(mem_rdat_i), .op_mode_o(op_mode_o));

  mzbi_mem_model i_mem (
    .clk_i(clk_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_adr_i(mem_adr_o),
    .mem_wdat_i(mem_wdat_o), .mem_wdat_oe_i(mem_wdat_oe_o), .mem_rdat_o(mem_rdat_i));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One classic cycle; lat counts edges from take to answer
  task automatic bus(input logic we, input logic [23:0] adr, input logic [15:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    lat = -1;
    do begin
      @(posedge clk_i);
      lat++;
    end while (!wb_ack_o && !wb_err_o && lat < 40);
    if (!wb_ack_o && !wb_err_o) chk("bus_answer", 16'h0, 16'h1);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    foreach (boot_tab[i]) begin
      rst_i <= 1'b1;
      boot_config_pins_i <= boot_tab[i][6:4];
      flash_blank_i <= boot_tab[i][3];
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("op_mode", {13'h0, op_mode_o}, {13'h0, boot_tab[i][2:0]});
      bus(1'b0, 24'h000100, 16'h0);
    end
    bus(1'b0, 24'hfff900, 16'h0);
    chk("wtc_reset", rd, 16'h0007);
    chk("reg_lat", 16'(lat), 16'h1);
    for (int a = 2; a <= 8; a += 2) begin
      bus(1'b0, 24'hfff900 + 24'(a), 16'h0);
      chk("zone_reset", rd, 16'h069f);
    end
    bus(1'b0, 24'h050000, 16'h0);
    chk("rsv_err", {15'h0, er}, 16'h1);
    bus(1'b1, 24'hfff900, 16'h0006);
    bus(1'b0, 24'hfff900, 16'h0);
    chk("wtc_late", rd, 16'h0006);
    bus(1'b1, 24'hfff906, 16'h000a);
    bus(1'b1, 24'h400010, 16'hbeef);
    // Zone 0 before had post-idle set, so one idle clock precedes this cycle
    chk("late_wr_lat", 16'(lat), 16'h8);
    bus(1'b0, 24'h400010, 16'h0);
    chk("rd_data", rd, 16'hbeef);
    chk("norm_rd_lat", 16'(lat), 16'h7);
    bus(1'b1, 24'hfff900, 16'h0007);
    bus(1'b1, 24'h400012, 16'h1234);
    chk("early_wr_lat", 16'(lat), 16'h8);
    bus(1'b1, 24'hfff900, 16'h0006);
    bus(1'b1, 24'hfff906, 16'h080a);
    bus(1'b0, 24'h400012, 16'h0);
    chk("fast_rd", rd, 16'h1234);
    chk("fast_lat", 16'(lat), 16'h3);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 24'hfff908, {11'h0, k[0] ? 2'h3 : 2'h0, k[1] ? 3'h7 : 3'h0});
      bus(1'b0, 24'h800000, 16'h0);
      chk("z2_lat", 16'(lat), 16'(4 + (k[1] ? 7 : 0) + (k[0] ? 3 : 0)));
    end
    bus(1'b0, 24'hfff908, 16'h0);
    chk("z2_cfg", rd, 16'h001f);
    bus(1'b0, 24'hfff90a, 16'h0);
    chk("mode_stat", rd, 16'h0000);
    bus(1'b0, 24'h0d0000, 16'h0);
    print_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    #500us;
    err_count++;
    print_verdict();
  end
endmodule : mzbi_bus_interface_unit_test
`default_nettype wire
